/* hdl/drive_status_pkg.sv */
// constants and types for the drive status and command word block
// Notes on behaviour
// - status word is read-only 16 bits; bit 2 shows extended dc-link voltage
// - bit 3 follows the energy saving function
// - bit 4 follows output frequency reduction
// - bit 6 shows deceleration ramp, bit 7 acceleration ramp
// - bit 8 set while ramp progression is frozen
// - bit 9 set once output frequency reaches reference
// - bit 10 follows dc-link voltage regulation
// - bit 11 is 1 for 50 Hz defaults, 0 for 60 Hz
// - bit 12 set while supply-dip ride-through runs
// - bit 13 set while spinning-motor catch start runs
// - bit 14 follows dc injection braking
// - bit 15 follows pwm pulse enable
// - bits 0, 1 and 5 are reserved and read zero
// - error action codes: 0 none,1 ramp stop,2 disable,3 local,4 local keep,5 fault
// - serial timeout counts as comm error, flagged as alarm or fault
// - on error the action is written into the serial/usb command word, only while the serial group controls
// - fault action blocks operation even without network control
// - two command words: serial/usb group and fieldbus group
// - each command word written only by its own interface
// - ramp run 0 decelerates to stop, 1 accelerates to reference
// - enable 0 cuts motor power, 1 permits operation
// - writing 1 to fault reset clears fault; 0 does nothing
package drive_status_pkg;
    localparam int WORD_W = 16;
    localparam int ACT_W = 3;
    // status bit positions
    localparam int ST_DCEXT = 2;
    localparam int ST_ENSAVE = 3;
    localparam int ST_FREQRED = 4;
    localparam int ST_DECEL = 6;
    localparam int ST_ACCEL = 7;
    localparam int ST_FROZEN = 8;
    localparam int ST_SETOK = 9;
    localparam int ST_DCREG = 10;
    localparam int ST_CFG50 = 11;
    localparam int ST_RIDE = 12;
    localparam int ST_CATCH = 13;
    localparam int ST_DCBRAKE = 14;
    localparam int ST_PWM = 15;
    // command bit positions
    localparam int CW_RUN = 0;
    localparam int CW_ENABLE = 1;
    localparam int CW_FWD = 2;
    localparam int CW_INCH = 3;
    localparam int CW_REMOTE = 4;
    localparam int CW_RAMP2 = 5;
    localparam int CW_FAULTRST = 7;
    // writable bits of a command word, reserved bits masked
    localparam logic [15:0] CW_MASK = 16'h00BF;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [2:0] ACTION_RESET = 3'h1;
    typedef enum logic [2:0] {
        ACT_NONE = 3'h0,
        ACT_RAMP_STOP = 3'h1,
        ACT_DISABLE = 3'h2,
        ACT_LOCAL = 3'h3,
        ACT_LOCAL_KEEP = 3'h4,
        ACT_FAULT = 3'h5
    } comm_action_t;
    // control source of the drive
    typedef enum logic [1:0] {
        SRC_LOCAL = 2'h0,
        SRC_SERIAL = 2'h1,
        SRC_FIELDBUS = 2'h2
    } ctrl_src_t;
endpackage

/* hdl/cmd_word_reg.sv */
// one network command word with write ownership and error override
`timescale 1ns/1ps
module cmd_word_reg (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ownWrite,
    input wire logic [15:0] ownData,
    input wire logic errApply,
    input wire logic [2:0] errAction,
    output logic [15:0] word
);
    logic [15:0] forced;
    // error action rewrites only the affected command bits
    always_comb begin
        forced = word;
        case (errAction)
            3'h1: forced[drive_status_pkg::CW_RUN] = 1'b0;
            3'h2: forced[drive_status_pkg::CW_ENABLE] = 1'b0;
            3'h3: begin
                forced[drive_status_pkg::CW_REMOTE] = 1'b0;
                forced[drive_status_pkg::CW_ENABLE] = 1'b0;
            end
            3'h4: forced[drive_status_pkg::CW_REMOTE] = 1'b0;
            default: forced = word;
        endcase
    end
    // error override beats a same-cycle write so the safe action holds
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            word <= drive_status_pkg::CMD_RESET;
        end else if (errApply) begin
            word <= forced;
        end else if (ownWrite) begin
            word <= ownData & drive_status_pkg::CW_MASK;
        end
    end
endmodule

/* hdl/drive_status_control.sv */
// status word, error action selector and two command words of the drive
`timescale 1ns/1ps
module drive_status_control (
    input wire logic mclk,
    input wire logic sys_rst,
    // drive function levels, same clock domain
    input wire logic dcExtActive,
    input wire logic energySaveActive,
    input wire logic freqReduceActive,
    input wire logic decelRamp,
    input wire logic accelRamp,
    input wire logic rampFrozen,
    input wire logic setpointReached,
    input wire logic dcRegActive,
    input wire logic defaults50Hz,
    input wire logic rideThroughActive,
    input wire logic catchStartActive,
    input wire logic dcBrakeActive,
    input wire logic pwmEnabled,
    // network master access
    input wire logic serialWrite,
    input wire logic [15:0] serialData,
    input wire logic fieldbusWrite,
    input wire logic [15:0] fieldbusData,
    input wire logic actionWrite,
    input wire logic [2:0] actionData,
    // which source controls the drive
    input wire logic [1:0] ctrlSource,
    // serial timeout event, one-cycle pulse
    input wire logic serialTimeout,
    input wire logic faultIsAlarm,
    output logic [15:0] driveFunctionStatus,
    output logic [2:0] commErrorActionSelect,
    output logic [15:0] serialUsbCommandWord,
    output logic [15:0] fieldbusCommandWord,
    output logic [15:0] activeCommandWord,
    output logic commTimeoutAlarm,
    output logic commTimeoutFault,
    output logic faultActive,
    output logic rampRun,
    output logic driveEnable,
    output logic forwardDir,
    output logic inchingSel,
    output logic remoteSel,
    output logic secondRamp,
    output logic goLocal
);
    logic [15:0] next_status;
    logic errSerial;
    logic applySerial;
    logic applyField;
    logic serialOwns;
    logic fieldOwns;
    logic errIsFault;
    logic faultReset;
    logic [15:0] selWord;

    // assemble the status word, reserved bits stay zero
    always_comb begin
        next_status = drive_status_pkg::STATUS_RESET;
        next_status[drive_status_pkg::ST_DCEXT] = dcExtActive;
        next_status[drive_status_pkg::ST_ENSAVE] = energySaveActive;
        next_status[drive_status_pkg::ST_FREQRED] = freqReduceActive;
        next_status[drive_status_pkg::ST_DECEL] = decelRamp;
        next_status[drive_status_pkg::ST_ACCEL] = accelRamp;
        next_status[drive_status_pkg::ST_FROZEN] = rampFrozen;
        next_status[drive_status_pkg::ST_SETOK] = setpointReached;
        next_status[drive_status_pkg::ST_DCREG] = dcRegActive;
        next_status[drive_status_pkg::ST_CFG50] = defaults50Hz;
        next_status[drive_status_pkg::ST_RIDE] = rideThroughActive;
        next_status[drive_status_pkg::ST_CATCH] = catchStartActive;
        next_status[drive_status_pkg::ST_DCBRAKE] = dcBrakeActive;
        next_status[drive_status_pkg::ST_PWM] = pwmEnabled;
    end

    // registered so a read sees a coherent word
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            driveFunctionStatus <= drive_status_pkg::STATUS_RESET;
        end else begin
            driveFunctionStatus <= next_status;
        end
    end

    // action selector; codes above 5 are refused and the old value kept
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            commErrorActionSelect <= drive_status_pkg::ACTION_RESET;
        end else if (actionWrite && actionData <= 3'h5) begin
            commErrorActionSelect <= actionData;
        end
    end

    // timeout is the only comm error source, tied to serial group
    assign errSerial = serialTimeout;
    assign serialOwns = ctrlSource == drive_status_pkg::SRC_SERIAL;
    assign fieldOwns = ctrlSource == drive_status_pkg::SRC_FIELDBUS;
    assign errIsFault = commErrorActionSelect == 3'h5;
    // overrides only land when the group really controls the drive
    assign applySerial = errSerial && serialOwns;
    assign applyField = 1'b0;

    // alarm or fault flag, sticky until cleared by a fault reset
    assign faultReset = serialWrite && serialData[drive_status_pkg::CW_FAULTRST]
        || fieldbusWrite && fieldbusData[drive_status_pkg::CW_FAULTRST];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            commTimeoutAlarm <= 1'b0;
            commTimeoutFault <= 1'b0;
        end else begin
            // set wins over a same-cycle clear
            if (errSerial && !(errIsFault && !faultIsAlarm)) begin
                commTimeoutAlarm <= 1'b1;
            end else if (faultReset) begin
                commTimeoutAlarm <= 1'b0;
            end
            if (errSerial && errIsFault && !faultIsAlarm) begin
                commTimeoutFault <= 1'b1;
            end else if (faultReset) begin
                commTimeoutFault <= 1'b0;
            end
        end
    end
    assign faultActive = commTimeoutFault;

    // serial/usb group word
    cmd_word_reg serialReg (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ownWrite(serialWrite),
        .ownData(serialData),
        .errApply(applySerial),
        .errAction(commErrorActionSelect),
        .word(serialUsbCommandWord)
    );

    // fieldbus group word
    cmd_word_reg fieldReg (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ownWrite(fieldbusWrite),
        .ownData(fieldbusData),
        .errApply(applyField),
        .errAction(commErrorActionSelect),
        .word(fieldbusCommandWord)
    );

    // word of the controlling group, zero under local control
    assign selWord = serialOwns ? serialUsbCommandWord :
        fieldOwns ? fieldbusCommandWord : 16'h0000;
    assign activeCommandWord = selWord;
    // a fault blocks the drive whatever the control source
    assign rampRun = selWord[drive_status_pkg::CW_RUN] && !faultActive;
    assign driveEnable = selWord[drive_status_pkg::CW_ENABLE]
        && !faultActive;
    assign forwardDir = selWord[drive_status_pkg::CW_FWD];
    assign inchingSel = selWord[drive_status_pkg::CW_INCH];
    assign remoteSel = selWord[drive_status_pkg::CW_REMOTE];
    assign secondRamp = selWord[drive_status_pkg::CW_RAMP2];
    // local request while a network group controls and its remote bit is clear
    assign goLocal = (serialOwns || fieldOwns) && !remoteSel;
endmodule

/* bench/drive_status_control_asserts.sv */
// concurrent checks on the drive status and command word ports
`timescale 1ns/1ps
module drive_status_control_asserts (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pwmEnabled,
    input wire logic defaults50Hz,
    input wire logic serialWrite,
    input wire logic [15:0] serialData,
    input wire logic fieldbusWrite,
    input wire logic [15:0] fieldbusData,
    input wire logic actionWrite,
    input wire logic [2:0] actionData,
    input wire logic [1:0] ctrlSource,
    input wire logic serialTimeout,
    input wire logic faultIsAlarm,
    input wire logic [15:0] driveFunctionStatus,
    input wire logic [2:0] commErrorActionSelect,
    input wire logic [15:0] serialUsbCommandWord,
    input wire logic [15:0] fieldbusCommandWord,
    input wire logic commTimeoutAlarm,
    input wire logic commTimeoutFault,
    input wire logic driveEnable,
    input wire logic rampRun
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // timeout while the serial group is in control
    sequence s_ser_err(logic [2:0] a);
        serialTimeout && ctrlSource == 2'h1 && commErrorActionSelect == a;
    endsequence
    sequence s_fault_req;
        serialTimeout && commErrorActionSelect == 3'h5 && !faultIsAlarm;
    endsequence
    a_pwm_follow: assert property (!$past(sys_rst) |->
        driveFunctionStatus[15] == $past(pwmEnabled)) else $error("pwm bit");
    a_cfg50_follow: assert property (!$past(sys_rst) |->
        driveFunctionStatus[11] == $past(defaults50Hz)) else $error("50 bit");
    a_reserved_zero: assert property (driveFunctionStatus[1:0] == 2'h0
        && !driveFunctionStatus[5]) else $error("reserved bit set");
    a_action_write: assert property (actionWrite && actionData <= 3'h5
        |=> commErrorActionSelect == $past(actionData)) else $error("action");
    a_serial_store: assert property (serialWrite && !serialTimeout |=>
        serialUsbCommandWord == ($past(serialData) & 16'h00BF))
        else $error("serial word");
    a_field_store: assert property (fieldbusWrite |=>
        fieldbusCommandWord == ($past(fieldbusData) & 16'h00BF))
        else $error("fieldbus word");
    a_ramp_stop: assert property (s_ser_err(3'h1) |=>
        !serialUsbCommandWord[0]) else $error("ramp stop");
    a_fault_raise: assert property (s_fault_req |=>
        commTimeoutFault) else $error("fault not raised");
    a_fault_blocks: assert property (commTimeoutFault |->
        !driveEnable && !rampRun) else $error("fault not blocking");
    a_alarm_set: assert property (serialTimeout &&
        commErrorActionSelect inside {[3'h1:3'h4]} |=> commTimeoutAlarm)
        else $error("alarm not raised");
endmodule
bind drive_status_control drive_status_control_asserts chk_u (.*);

/* bench/net_master.sv */
// network master model writing command words and the action selector
`timescale 1ns/1ps
module net_master (
    input wire logic mclk,
    output logic serialWrite = 1'b0,
    output logic [15:0] serialData = 16'h0000,
    output logic fieldbusWrite = 1'b0,
    output logic [15:0] fieldbusData = 16'h0000,
    output logic actionWrite = 1'b0,
    output logic [2:0] actionData = 3'h0
);
    // g: 0 serial, 1 fieldbus, 2 action; only one own strobe per write
    task put(input logic [1:0] g, input logic [15:0] d);
        @(posedge mclk);
        serialWrite <= g == 2'h0;
        fieldbusWrite <= g == 2'h1;
        actionWrite <= g == 2'h2;
        serialData <= d;
        fieldbusData <= d;
        actionData <= d[2:0];
        @(posedge mclk);
        {serialWrite, fieldbusWrite, actionWrite} <= 3'h0;
        // released data shows junk, not the last value
        serialData <= ~d;
        fieldbusData <= ~d;
        actionData <= ~d[2:0];
    endtask
endmodule

/* bench/drive_status_control_tb.sv */
// self-checking bench for the drive status and command word block
`timescale 1ns/1ps
module drive_status_control_tb;
    logic mclk = 1'b0, sys_rst = 1'b1, faultIsAlarm = 1'b0;
    logic serialTimeout = 1'b0, serialWrite, fieldbusWrite, actionWrite;
    logic [1:0] ctrlSource = 2'h0;
    logic [12:0] fn = 13'h0;
    logic [15:0] serialData, fieldbusData, driveFunctionStatus;
    logic [15:0] serialUsbCommandWord, fieldbusCommandWord, activeCommandWord;
    logic [2:0] actionData, commErrorActionSelect;
    logic commTimeoutAlarm, commTimeoutFault, faultActive, rampRun, goLocal;
    logic driveEnable, forwardDir, inchingSel, remoteSel, secondRamp;
    int mismatches = 0, tests_run = 0, cyc = 0;
    int pos[13] = '{2, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};
    logic [15:0] expw[6] = '{16'h0013, 16'h0012, 16'h0011, 16'h0001,
        16'h0003, 16'h0013};
    drive_status_control dut_u (.*, .dcExtActive(fn[0]),
        .energySaveActive(fn[1]), .freqReduceActive(fn[2]),
        .decelRamp(fn[3]), .accelRamp(fn[4]), .rampFrozen(fn[5]),
        .setpointReached(fn[6]), .dcRegActive(fn[7]), .defaults50Hz(fn[8]),
        .rideThroughActive(fn[9]), .catchStartActive(fn[10]),
        .dcBrakeActive(fn[11]), .pwmEnabled(fn[12]));
    net_master master_u (.*);
    always #5 mclk = ~mclk;
    // hang guard, the whole run needs well under 500 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            results();
        end
    end
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task t_status;
        for (int i = 0; i < 13; i++) begin
            @(posedge mclk);
            fn <= 13'h1 << i;
            tick(2);
            chk("status", driveFunctionStatus, 16'h1 << pos[i]);
        end
        @(posedge mclk);
        fn <= 13'h1FFF;
        tick(2);
        chk("status all", driveFunctionStatus, 16'hFFDC);
    endtask
    task t_words;
        master_u.put(2'h0, 16'hFFFF);
        master_u.put(2'h1, 16'h0155);
        tick(1);
        chk("serial", serialUsbCommandWord, 16'h00BF);
        chk("fieldbus", fieldbusCommandWord, 16'h0015);
        @(posedge mclk);
        ctrlSource <= 2'h1;
        master_u.put(2'h0, 16'h0035);
        tick(1);
        chk("bits", {rampRun, driveEnable, forwardDir, inchingSel, remoteSel,
            secondRamp}, 6'b101011);
        @(posedge mclk);
        ctrlSource <= 2'h2;
        tick(1);
        chk("active", activeCommandWord, 16'h0015);
    endtask
    task t_actions;
        for (int a = 0; a < 6; a++) begin
            @(posedge mclk);
            ctrlSource <= (a == 5) ? 2'h0 : 2'h1;
            master_u.put(2'h0, 16'h0013);
            master_u.put(2'h2, 16'(a));
            @(posedge mclk);
            serialTimeout <= 1'b1;
            @(posedge mclk);
            serialTimeout <= 1'b0;
            tick(1);
            chk("word", serialUsbCommandWord, expw[a]);
            // timeout is always flagged, sticky from the first pass on
            chk("alarm", commTimeoutAlarm, 1'b1);
            chk("fault", commTimeoutFault, a == 5);
            chk("fault act", faultActive, a == 5);
            chk("enable", driveEnable, a < 5 && expw[a][1]);
            chk("local", goLocal, a < 5 && !expw[a][4]);
        end
        master_u.put(2'h2, 16'h0006);
        master_u.put(2'h0, 16'h0080);
        tick(1);
        chk("select", commErrorActionSelect, 3'h5);
        chk("fault rst", commTimeoutFault, 1'b0);
        chk("alarm rst", commTimeoutAlarm, 1'b0);
        // alarm form of the fault action raises the alarm flag only
        @(posedge mclk);
        faultIsAlarm <= 1'b1;
        serialTimeout <= 1'b1;
        @(posedge mclk);
        serialTimeout <= 1'b0;
        tick(1);
        chk("alarm form", commTimeoutAlarm, 1'b1);
        chk("no fault", commTimeoutFault, 1'b0);
    endtask
    // mid-run reset clears words, flags and status, selector back to 1
    task t_reset;
        @(posedge mclk);
        sys_rst <= 1'b1;
        tick(2);
        chk("rst status", driveFunctionStatus, 16'h0000);
        chk("rst serial", serialUsbCommandWord, 16'h0000);
        chk("rst field", fieldbusCommandWord, 16'h0000);
        chk("rst select", commErrorActionSelect, 3'h1);
        chk("rst alarm", commTimeoutAlarm, 1'b0);
        @(posedge mclk);
        sys_rst <= 1'b0;
        tick(1);
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        tick(1);
        chk("select rst", commErrorActionSelect, 3'h1);
        chk("word rst", serialUsbCommandWord, 16'h0000);
        t_status();
        t_words();
        t_actions();
        t_reset();
        results();
    end
endmodule
